// *** bench/dmc_mover_model.sv ***
// Behavioural packet mover on the far side of the lane register block.
// Assumes one shared clock; answers each outstanding packet with one ack.
`default_nettype none
module dmc_mover_model (
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst,
  input  wire logic        i_req,
  input  wire logic        i_slow,
  input  wire logic        i_err_cmd,
  output logic             o_ack,
  output logic      [31:0] o_data,
  output logic             o_err
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] seed;
  logic [1:0]  wait_c;
  logic        hold;
  // ----------------------------------------
  // Answer timing
  // ----------------------------------------
  // Data lines off the ack cycle invert every cycle, starting from the last word
  always_ff @(posedge i_ref_clk) begin
    o_ack  <= 1'b0;
    o_err  <= 1'b0;
    o_data <= ~o_data;
    if (i_rst) begin
      hold   <= 1'b0;
      wait_c <= 2'h0;
      seed   <= 32'h5a5a0001;
      o_data <= 32'h00000000;
    end else if (o_ack) begin
      hold <= 1'b1;
    end else if (hold) begin
      // Wait for the request to fall before another answer
      if (!i_req) hold <= 1'b0;
    end else if (!i_req) begin
      wait_c <= 2'h0;
    end else if (wait_c == (i_slow ? 2'h3 : 2'h0)) begin
      o_ack  <= 1'b1;
      o_err  <= i_err_cmd;
      o_data <= seed;
      seed   <= seed + 32'h01020304;
      wait_c <= 2'h0;
    end else begin
      wait_c <= wait_c + 2'h1;
    end
  end
endmodule
`default_nettype wire

// *** bench/tb_dmc_core.sv ***
// Self-checking bench for the 14-lane DMA register block.
// Assumes dmc_pkg, dmc_core and dmc_mover_model are compiled first.
`default_nettype none
module tb_dmc_core;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_ref_clk, i_rst, i_wr, i_rd, rd_q, slow, err_cmd;
  logic        o_irq, o_xfer_req, o_xfer_dir, ack, xerr, req_q, ce;
  logic [9:0]  i_addr;
  logic [31:0] i_wdata, o_rdata, xdata, last_data;
  logic [31:0] o_xfer_mem_addr, o_xfer_peer_addr, v [14];
  logic [31:0] rnd = 32'hcd0095f1;
  logic [13:0] i_flow_req, i_flow_term;
  logic [3:0]  o_xfer_chan;
  logic [2:0]  o_xfer_size;
  logic [71:0] rq [$];
  logic [71:0] xq [$];
  int          n_mismatch = 0;
  int          cmp_count = 0;
  int          n_pkt = 0;
  int          n_ack = 0;

  dmc_core uut (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_ce(ce),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .o_irq(o_irq),
    .i_flow_req(i_flow_req), .i_flow_term(i_flow_term),
    .o_xfer_req(o_xfer_req), .o_xfer_chan(o_xfer_chan),
    .o_xfer_mem_addr(o_xfer_mem_addr),
    .o_xfer_peer_addr(o_xfer_peer_addr),
    .o_xfer_dir(o_xfer_dir), .o_xfer_size(o_xfer_size),
    .i_xfer_ack(ack), .i_xfer_data(xdata), .i_xfer_err(xerr)
  );
  dmc_mover_model mover (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_req(o_xfer_req),
    .i_slow(slow), .i_err_cmd(err_cmd),
    .o_ack(ack), .o_data(xdata), .o_err(xerr)
  );
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [9:0] lb(input int n);
    return 10'(10'h040 * (n + 1));
  endfunction
  task automatic check(input logic [71:0] seen, input logic [71:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [9:0] a, input logic [31:0] e);
    @(posedge i_ref_clk);
    rq.push_back(72'(e));
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
  endtask
  task automatic irq_is(input logic e);
    repeat (2) @(posedge i_ref_clk);
    @(negedge i_ref_clk);
    check(72'(o_irq), 72'(e));
  endtask
  task automatic wait_n(ref int cnt, input int k);
    for (int t = 0; t < 300 && cnt < k; t++) @(posedge i_ref_clk);
  endtask
  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // ----------------------------------------
  // Clock, monitor, watchdog
  // ----------------------------------------
  initial begin
    i_ref_clk = 1'b0;
    forever #4 i_ref_clk = ~i_ref_clk;
  end
  always @(posedge i_ref_clk) rd_q <= i_rd;
  // Outputs are judged mid-cycle, after every edge update has landed
  always @(negedge i_ref_clk) begin
    if (rd_q) check(72'(o_rdata), rq.size() ? rq.pop_front() : 'x);
    if (o_xfer_req && !req_q) begin
      n_pkt++;
      check({o_xfer_dir, o_xfer_chan, o_xfer_size, o_xfer_mem_addr,
             o_xfer_peer_addr}, xq.size() ? xq.pop_front() : 'x);
    end
    if (ack && o_xfer_req) begin
      n_ack++;
      last_data = xdata;
    end
    req_q = o_xfer_req;
  end
  initial begin
    repeat (20000) @(posedge i_ref_clk);
    n_mismatch++;
    wrap_up();
  end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    {i_rst, i_wr, i_rd, slow, err_cmd, ce} = 6'h21;
    {i_addr, i_wdata, i_flow_req, i_flow_term} = '0;
    repeat (8) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    rd(10'h000, 0);
    wr(10'h004, 32'hffffffff);
    wr(lb(2) + 10'h01c, 32'hffffffff);
    wr(lb(5), 32'hffffffff);
    wr(lb(5) + 10'h018, 32'hffffffff);
    rd(10'h004, 0);
    rd(10'h008, 0);
    rd(lb(2) + 10'h01c, 0);
    rd(lb(5), 1);
    rd(lb(5) + 10'h018, 7);
    $display("reset and reserved test done");
    for (int n = 0; n < 14; n++) begin
      rnd = lfsr(rnd);
      v[n] = rnd;
      wr(lb(n) + 10'h004 + 10'(4 * (n % 3)), rnd);
    end
    for (int n = 0; n < 14; n++)
      rd(lb(n) + 10'h004 + 10'(4 * (n % 3)), v[n]);
    for (int n = 0; n < 3; n++) begin
      for (int o = 0; o < 2; o++) begin
        rnd = lfsr(rnd);
        wr(lb(n) + 10'(32 + 4 * o), rnd);
        rd(lb(n) + 10'(32 + 4 * o), n < 2 ? rnd : 0);
      end
    end
    rd(lb(0) + 10'h028, 0);
    rd(lb(1) + 10'h028, 0);
    wr(lb(4) + 10'h010, 32'hffffffff);
    rd(lb(4) + 10'h010, 32'h037fff05);
    i_flow_req <= 14'h0010;
    wr(lb(4) + 10'h010, 0);
    rd(lb(4) + 10'h010, 32'h00000002);
    i_flow_req <= 14'h0000;
    $display("register map test done");
    // Firmware-paced lane 2, slow mover, memory and peer stepping
    slow <= 1'b1;
    wr(lb(2) + 10'h004, 32'h00000100);
    wr(lb(2) + 10'h008, 32'h0000010c);
    wr(lb(2) + 10'h00c, 32'h00002000);
    wr(10'h000, 1);
    wr(lb(2) + 10'h010, 32'h014b0100);
    repeat (12) @(posedge i_ref_clk);
    check(72'(n_pkt), 0);
    wr(10'h000, 0);
    wr(lb(2), 1);
    repeat (12) @(posedge i_ref_clk);
    check(72'(n_pkt), 0);
    for (int k = 0; k < 3; k++)
      xq.push_back({1'b1, 4'h2, 3'h4, 32'(32'h100 + 4 * k),
                    32'(32'h2000 + 4 * k)});
    wr(10'h000, 1);
    wait_n(n_ack, 3);
    repeat (12) @(posedge i_ref_clk);
    check(72'(n_pkt), 3);
    rd(lb(2) + 10'h004, 32'h0000010c);
    rd(lb(2) + 10'h00c, 32'h0000200c);
    rd(lb(2) + 10'h014, 32'h00000004);
    rd(lb(2) + 10'h010, 32'h004b0100);
    rd(10'h004, last_data);
    irq_is(1'b0);
    wr(lb(2) + 10'h018, 32'h00000004);
    irq_is(1'b1);
    wr(lb(2) + 10'h014, 32'h00000004);
    irq_is(1'b0);
    $display("firmware paced test done");
    // Hardware-paced lane 3: no memory stepping, bus errors
    slow    <= 1'b0;
    err_cmd <= 1'b1;
    wr(lb(3) + 10'h004, 32'h00000040);
    wr(lb(3) + 10'h008, 32'h00000080);
    wr(lb(3) + 10'h00c, 32'h00000010);
    wr(lb(3), 1);
    wr(lb(3) + 10'h010, 32'h00220001);
    for (int k = 0; k < 3; k++)
      xq.push_back({1'b0, 4'h3, 3'h2, 32'h40,
                    32'(32'h10 + 2 * k)});
    i_flow_req <= 14'h0008;
    wait_n(n_ack, 6);
    i_flow_req <= 14'h0000;
    err_cmd    <= 1'b0;
    repeat (10) @(posedge i_ref_clk);
    check(72'(n_pkt), 6);
    rd(lb(3) + 10'h004, 32'h00000040);
    rd(lb(3) + 10'h00c, 32'h00000016);
    rd(lb(3) + 10'h014, 32'h00000001);
    // Terminate drops the packet without stepping
    slow <= 1'b1;
    xq.push_back({1'b0, 4'h3, 3'h2, 32'h40, 32'h16});
    i_flow_req <= 14'h0008;
    wait_n(n_pkt, 7);
    i_flow_term <= 14'h0008;
    @(posedge i_ref_clk);
    i_flow_req <= 14'h0000;
    @(posedge i_ref_clk);
    i_flow_term <= 14'h0000;
    repeat (10) @(posedge i_ref_clk);
    check(72'(n_ack), 6);
    rd(lb(3) + 10'h00c, 32'h00000016);
    // Master asking at the limit flags an overrun, moves nothing
    wr(lb(3) + 10'h008, 32'h00000040);
    wr(lb(3) + 10'h010, 32'h00210001);
    i_flow_req <= 14'h0008;
    repeat (4) @(posedge i_ref_clk);
    i_flow_req <= 14'h0000;
    rd(lb(3) + 10'h014, 32'h00000003);
    check(72'(n_pkt), 7);
    // Frozen block ignores the port
    ce <= 1'b0;
    wr(lb(3) + 10'h004, 32'h00000055);
    ce <= 1'b1;
    rd(lb(3) + 10'h004, 32'h00000040);
    $display("hardware paced test done");
    wr(10'h000, 32'h00000003);
    rd(10'h000, 0);
    rd(lb(2) + 10'h004, 0);
    rd(lb(3) + 10'h014, 0);
    rd(lb(0) + 10'h020, 0);
    $display("soft reset test done");
    wrap_up();
  end
endmodule
`default_nettype wire

// *** core/dmc_core.sv ***
// DMA channel register map and packet address progression, 14 lanes.
// Assumes same-clock packet mover answering o_xfer_req with i_xfer_ack,
// and flow-control masters on the same clock.
//
// Summary of operation
// - Main block at 0x000, channel n set at 0x040*(n+1), last at 0x380.
// - Channel register address is base plus channel offset plus offset.
// - Writing one to main bit 1 resets the whole module; self-clearing.
// - Main bit 0 enables block; zero disables all lanes; resets zero.
// - Lane runs only with its enable bit and block enable both set.
// - Read-only debug word at 0x04 shows last packet data read.
// - With memory stepping on, memory cursor grows by packet size.
// - Memory side is the slave, not tied to the flow master.
// - Memory stepping: cursor equal to limit ends transfer, sets flag.
// - With peer stepping on, peer cursor grows by packet size.
// - Peer cursor is the address given to the transfer master.
// - Only channel 0 has checksum registers at 0x20..0x24.
// - Only channel 1 has fill registers at 0x20..0x28.
// - Control 0x10, event flags 0x14, event mask 0x18 per lane.
// - Without memory stepping, lane never ends a transfer itself.
`default_nettype none
module dmc_core (
  input  wire logic                 i_ref_clk,
  input  wire logic                 i_rst,
  input  wire logic                 i_ce,
  input  wire logic [9:0]           i_addr,
  input  wire logic [31:0]          i_wdata,
  input  wire logic                 i_wr,
  input  wire logic                 i_rd,
  output logic      [31:0]          o_rdata,
  output logic                      o_irq,
  input  wire logic [13:0]          i_flow_req,
  input  wire logic [13:0]          i_flow_term,
  output logic                      o_xfer_req,
  output logic      [3:0]           o_xfer_chan,
  output logic      [31:0]          o_xfer_mem_addr,
  output logic      [31:0]          o_xfer_peer_addr,
  output logic                      o_xfer_dir,
  output logic      [2:0]           o_xfer_size,
  input  wire logic                 i_xfer_ack,
  input  wire logic [31:0]          i_xfer_data,
  input  wire logic                 i_xfer_err
);

  dmc_pkg::dmc_state_t st_reg;
  dmc_pkg::dmc_state_t st_next;

  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------
  // window decode
  // Bit 4 says a lane is hit, low bits give the lane index
  function automatic logic [4:0] lane_of(input logic [9:0] a);
    logic [3:0] w;
    w = a[9:6];
    if (w != 4'h0 && w <= 4'(dmc_pkg::NUM_CH)) begin
      lane_of = {1'b1, 4'(w - 4'h1)};
    end else begin
      lane_of = 5'h00;
    end
  endfunction

  function automatic logic at_limit(input dmc_pkg::dmc_ch_t c);
    at_limit = c.ctl[dmc_pkg::B_MEM_STEP] && (c.mc == c.ml);
  endfunction

  logic [4:0]  dec;
  logic [3:0]  li;
  logic [5:0]  ofs;
  logic        is_main;
  logic [13:0] elig;

  assign dec     = lane_of(i_addr);
  assign li      = dec[3:0];
  assign ofs     = i_addr[5:0];
  assign is_main = (i_addr[9:6] == 4'h0);

  // ------------------------------------------------------------
  // Lane eligibility
  // ------------------------------------------------------------
  for (genvar g = 0; g < dmc_pkg::NUM_CH; g++) begin : g_elig
    logic [31:0] c;
    logic        fw;
    logic        hw;
    assign c  = st_reg.ch[g].ctl;
    assign fw = c[dmc_pkg::B_NO_HWFC] && c[dmc_pkg::B_GO];
    assign hw = !c[dmc_pkg::B_NO_HWFC] && c[dmc_pkg::B_RUN]
                && i_flow_req[g];
    // block enable, lane enable, abort, pacing or limit stop a lane
    assign elig[g] = st_reg.blk_en && st_reg.ch[g].en
                     && !c[dmc_pkg::B_ABORT] && (fw || hw)
                     && !at_limit(st_reg.ch[g]);
  end

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    logic [3:0]  k;
    logic [3:0]  cu;
    logic [31:0] rd;
    logic [31:0] step;
    logic        found;
    logic        any;
    st_next = st_reg;
    st_next.rdata = dmc_pkg::RST_VAL;
    k     = 4'h0;
    cu    = st_reg.xf.chan;
    rd    = dmc_pkg::RST_VAL;
    step  = {29'h0, st_reg.xf.size};
    found = 1'b0;
    any   = 1'b0;

    // Register read, answered next cycle
    if (i_rd) begin
      if (is_main) begin
        if (ofs == dmc_pkg::OFS_MAIN) begin
          rd = {31'h0, st_reg.blk_en};
        end else if (ofs == dmc_pkg::OFS_DEBUG) begin
          rd = st_reg.staged;
        end
      end else if (dec[4]) begin
        case (ofs)
          dmc_pkg::OFS_ENABLE: rd = {31'h0, st_reg.ch[li].en};
          dmc_pkg::OFS_MCUR:   rd = st_reg.ch[li].mc;
          dmc_pkg::OFS_MLIM:   rd = st_reg.ch[li].ml;
          dmc_pkg::OFS_PCUR:   rd = st_reg.ch[li].pc;
          dmc_pkg::OFS_CTL: begin
            rd = st_reg.ch[li].ctl & dmc_pkg::CTL_WMASK;
            rd[dmc_pkg::B_BUSY] = elig[li]
              || (st_reg.xf.act && st_reg.xf.chan == li);
            rd[dmc_pkg::B_REQ] = i_flow_req[li];
            rd[dmc_pkg::B_DONE] = st_reg.ch[li].ctl[dmc_pkg::B_RUN]
              && !rd[dmc_pkg::B_BUSY];
          end
          dmc_pkg::OFS_FLAGS:  rd = {29'h0, st_reg.ch[li].flg};
          dmc_pkg::OFS_MASK:   rd = {29'h0, st_reg.ch[li].msk};
          dmc_pkg::OFS_XENA: begin
            if (li == dmc_pkg::CRC_CH) rd = st_reg.crc_en;
            else if (li == dmc_pkg::FILL_CH) rd = st_reg.fill_en;
          end
          dmc_pkg::OFS_XVAL: begin
            if (li == dmc_pkg::CRC_CH) rd = st_reg.crc_val;
            else if (li == dmc_pkg::FILL_CH) rd = st_reg.fill_val;
          end
          dmc_pkg::OFS_XSTAT: begin
            // Fill status reports the fill lane busy
            if (li == dmc_pkg::FILL_CH) begin
              rd = {31'h0, st_reg.xf.act
                    && st_reg.xf.chan == dmc_pkg::FILL_CH};
            end
          end
          default: rd = dmc_pkg::RST_VAL;
        endcase
      end
      st_next.rdata = rd;
    end

    // Register write; reserved bits are masked off
    if (i_wr) begin
      if (is_main && ofs == dmc_pkg::OFS_MAIN) begin
        st_next.blk_en = i_wdata[dmc_pkg::B_BLK_EN];
      end else if (dec[4]) begin
        case (ofs)
          dmc_pkg::OFS_ENABLE: st_next.ch[li].en = i_wdata[0];
          dmc_pkg::OFS_MCUR:   st_next.ch[li].mc = i_wdata;
          dmc_pkg::OFS_MLIM:   st_next.ch[li].ml = i_wdata;
          dmc_pkg::OFS_PCUR:   st_next.ch[li].pc = i_wdata;
          dmc_pkg::OFS_CTL:
            st_next.ch[li].ctl = i_wdata & dmc_pkg::CTL_WMASK;
          dmc_pkg::OFS_FLAGS:
            st_next.ch[li].flg = st_reg.ch[li].flg & ~i_wdata[2:0];
          dmc_pkg::OFS_MASK:   st_next.ch[li].msk = i_wdata[2:0];
          dmc_pkg::OFS_XENA: begin
            if (li == dmc_pkg::CRC_CH) st_next.crc_en = i_wdata;
            else if (li == dmc_pkg::FILL_CH) st_next.fill_en = i_wdata;
          end
          dmc_pkg::OFS_XVAL: begin
            if (li == dmc_pkg::CRC_CH) st_next.crc_val = i_wdata;
            else if (li == dmc_pkg::FILL_CH) st_next.fill_val = i_wdata;
          end
          default: st_next.ch[li].en = st_reg.ch[li].en;
        endcase
      end
    end

    // Flow overrun: master still asks after the limit was reached.
    // Flags are set after the clear above, so a set wins.
    for (int i = 0; i < dmc_pkg::NUM_CH; i++) begin
      if (!st_reg.ch[i].ctl[dmc_pkg::B_NO_HWFC]
          && st_reg.ch[i].ctl[dmc_pkg::B_RUN]
          && i_flow_req[i] && at_limit(st_reg.ch[i])) begin
        st_next.ch[i].flg[dmc_pkg::F_FLOW] = 1'b1;
      end
    end

    // --------------------------------------------------------
    // Packet engine
    // --------------------------------------------------------
    if (st_reg.xf.act) begin
      if (!elig[cu] || (i_flow_term[cu]
          && !st_reg.ch[cu].ctl[dmc_pkg::B_NO_HWFC])) begin
        // Abort, disable or terminate drops the packet at once
        st_next.xf.act = 1'b0;
      end else if (i_xfer_ack) begin
        st_next.xf.act = 1'b0;
        st_next.staged = i_xfer_data;
        if (i_xfer_err) begin
          st_next.ch[cu].flg[dmc_pkg::F_BUS_ERR] = 1'b1;
        end
        if (st_reg.ch[cu].ctl[dmc_pkg::B_MEM_STEP]) begin
          st_next.ch[cu].mc = st_reg.ch[cu].mc + step;
          if (st_reg.ch[cu].mc + step == st_reg.ch[cu].ml) begin
            st_next.ch[cu].flg[dmc_pkg::F_LIMIT] = 1'b1;
            st_next.ch[cu].ctl[dmc_pkg::B_GO] = 1'b0;
          end
        end
        if (st_reg.ch[cu].ctl[dmc_pkg::B_PEER_STEP]) begin
          st_next.ch[cu].pc = st_reg.ch[cu].pc + step;
        end
        // Locked lane keeps the arbiter pointing at itself
        st_next.rr = st_reg.ch[cu].ctl[dmc_pkg::B_LOCK] ? cu
                     : ((cu == 4'(dmc_pkg::NUM_CH - 1)) ? 4'h0
                        : 4'(cu + 4'h1));
      end
    end else begin
      // Round robin from the pointer; one packet per grant
      for (int j = 0; j < dmc_pkg::NUM_CH; j++) begin
        k = 4'((32'(st_reg.rr) + j) % dmc_pkg::NUM_CH);
        if (!found && elig[k]) begin
          found = 1'b1;
          st_next.xf.act  = 1'b1;
          st_next.xf.chan = k;
          st_next.xf.mem_addr = st_reg.ch[k].mc;
          st_next.xf.peer_addr = st_reg.ch[k].pc;
          st_next.xf.dir  = st_reg.ch[k].ctl[dmc_pkg::B_DIR];
          st_next.xf.size = st_reg.ch[k].ctl[dmc_pkg::B_SIZE_LO +: 3];
        end
      end
    end

    for (int i = 0; i < dmc_pkg::NUM_CH; i++) begin
      any = any | (|(st_next.ch[i].flg & st_next.ch[i].msk));
    end
    st_next.irq = any;

    // soft reset of the whole module
    if (i_wr && is_main && ofs == dmc_pkg::OFS_MAIN
        && i_wdata[dmc_pkg::B_SOFT_RST]) begin
      st_next = '0;
    end
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      st_reg <= '0;
    end else if (i_ce) begin
      st_reg <= st_next;
    end
  end

  assign o_rdata          = st_reg.rdata;
  assign o_irq            = st_reg.irq;
  assign o_xfer_req       = st_reg.xf.act;
  assign o_xfer_chan      = st_reg.xf.chan;
  assign o_xfer_mem_addr  = st_reg.xf.mem_addr;
  assign o_xfer_peer_addr = st_reg.xf.peer_addr;
  assign o_xfer_dir       = st_reg.xf.dir;
  assign o_xfer_size      = st_reg.xf.size;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst || !i_ce);

  property p_soft_reset;
    i_wr && is_main && ofs == dmc_pkg::OFS_MAIN && i_wdata[1]
      |=> !st_reg.blk_en && !o_xfer_req && !o_irq;
  endproperty
  a_soft_reset: assert property (p_soft_reset)
    else $error("soft reset did not clear state");

  property p_blk_off;
    !st_reg.blk_en && !i_wr |=> !o_xfer_req;
  endproperty
  a_blk_off: assert property (p_blk_off)
    else $error("packet requested while block disabled");

  // Index by the lane picked in the grant cycle, not the old lane
  property p_lane_en;
    $rose(o_xfer_req) |-> $past(st_reg.blk_en)
      && $past(st_reg.ch[st_next.xf.chan].en);
  endproperty
  a_lane_en: assert property (p_lane_en)
    else $error("packet started on disabled lane");

  property p_staged;
    o_xfer_req && i_xfer_ack && elig[o_xfer_chan]
      && !(i_flow_term[o_xfer_chan]) && !i_wr
      |=> st_reg.staged == $past(i_xfer_data);
  endproperty
  a_staged: assert property (p_staged)
    else $error("debug view missed packet data");

  property p_mem_step;
    o_xfer_req && i_xfer_ack && elig[o_xfer_chan] && !i_wr
      && !i_flow_term[o_xfer_chan]
      && st_reg.ch[o_xfer_chan].ctl[dmc_pkg::B_MEM_STEP]
      |=> st_reg.ch[$past(o_xfer_chan)].mc
          == $past(st_reg.ch[o_xfer_chan].mc) + 32'($past(o_xfer_size));
  endproperty
  a_mem_step: assert property (p_mem_step)
    else $error("memory cursor not advanced by packet size");

  for (genvar g = 0; g < dmc_pkg::NUM_CH; g++) begin : g_lim
    property p_limit_flag;
      @(posedge i_ref_clk) disable iff (i_rst || !i_ce)
      $rose(st_reg.ch[g].flg[dmc_pkg::F_LIMIT])
        |-> st_reg.ch[g].mc == st_reg.ch[g].ml;
    endproperty
    a_limit_flag: assert property (p_limit_flag)
      else $error("limit flag without cursor at limit");
  end

  property p_peer_addr;
    $rose(o_xfer_req) |-> o_xfer_peer_addr
      == $past(st_reg.ch[st_next.xf.chan].pc);
  endproperty
  a_peer_addr: assert property (p_peer_addr)
    else $error("peer address not taken from peer cursor");

  property p_reserved;
    i_rd && !is_main && !dec[4] |=> o_rdata == 32'h00000000;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("unmapped read returned nonzero");

  // Level view of the flags as they stand now
  logic irq_now;
  always_comb begin
    irq_now = 1'b0;
    for (int i = 0; i < dmc_pkg::NUM_CH; i++) begin
      irq_now = irq_now | (|(st_reg.ch[i].flg & st_reg.ch[i].msk));
    end
  end

  property p_irq;
    o_irq == irq_now;
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt level does not follow flags and mask");

endmodule
`default_nettype wire

// *** core/dmc_pkg.sv ***
// Constants and carrier types of the DMA channel register block.
// Assumes one clock domain and a single-cycle register port.
`default_nettype none
package dmc_pkg;
  localparam int          NUM_CH      = 14;
  localparam int          ADDR_W      = 10;
  // Channel window: index 0 is the main block, channel n at n+1
  localparam logic [9:0]  CH_STRIDE   = 10'h040;
  localparam logic [9:0]  CH0_BASE    = 10'h040;
  localparam logic [9:0]  CH13_BASE   = 10'h380;
  // Main block offsets
  localparam logic [5:0]  OFS_MAIN    = 6'h00;
  localparam logic [5:0]  OFS_DEBUG   = 6'h04;
  // Channel offsets
  localparam logic [5:0]  OFS_ENABLE  = 6'h00;
  localparam logic [5:0]  OFS_MCUR    = 6'h04;
  localparam logic [5:0]  OFS_MLIM    = 6'h08;
  localparam logic [5:0]  OFS_PCUR    = 6'h0c;
  localparam logic [5:0]  OFS_CTL     = 6'h10;
  localparam logic [5:0]  OFS_FLAGS   = 6'h14;
  localparam logic [5:0]  OFS_MASK    = 6'h18;
  localparam logic [5:0]  OFS_XENA    = 6'h20;
  localparam logic [5:0]  OFS_XVAL    = 6'h24;
  localparam logic [5:0]  OFS_XSTAT   = 6'h28;
  localparam logic [3:0]  CRC_CH      = 4'h0;
  localparam logic [3:0]  FILL_CH     = 4'h1;
  // Main control bits
  localparam int          B_BLK_EN    = 0;
  localparam int          B_SOFT_RST  = 1;
  // Channel control bits
  localparam int          B_RUN       = 0;
  localparam int          B_REQ       = 1;
  localparam int          B_DONE      = 2;
  localparam int          B_BUSY      = 5;
  localparam int          B_DIR       = 8;
  localparam int          B_MEM_STEP  = 16;
  localparam int          B_PEER_STEP = 17;
  localparam int          B_LOCK      = 18;
  localparam int          B_NO_HWFC   = 19;
  localparam int          B_SIZE_LO   = 20;
  localparam int          B_GO        = 24;
  localparam int          B_ABORT     = 25;
  localparam logic [31:0] CTL_WMASK   = 32'h037fff01;
  // Event flag bits
  localparam int          F_BUS_ERR   = 0;
  localparam int          F_FLOW      = 1;
  localparam int          F_LIMIT     = 2;
  localparam logic [31:0] RST_VAL     = 32'h00000000;

  typedef struct packed {
    logic        en;
    logic [31:0] mc;
    logic [31:0] ml;
    logic [31:0] pc;
    logic [31:0] ctl;
    logic [2:0]  flg;
    logic [2:0]  msk;
  } dmc_ch_t;

  typedef struct packed {
    logic                    act;
    logic [3:0]              chan;
    logic [31:0]             mem_addr;
    logic [31:0]             peer_addr;
    logic                    dir;
    logic [2:0]              size;
  } dmc_xfer_t;

  typedef struct packed {
    logic                    blk_en;
    logic [31:0]             staged;
    dmc_ch_t [NUM_CH-1:0]    ch;
    logic [31:0]             crc_en;
    logic [31:0]             crc_val;
    logic [31:0]             fill_en;
    logic [31:0]             fill_val;
    dmc_xfer_t               xf;
    logic [3:0]              rr;
    logic [31:0]             rdata;
    logic                    irq;
  } dmc_state_t;
endpackage
`default_nettype wire
